// file: shared/dpm_regs.svh
// Timing and address constants for the dual-port memory host controller
`ifndef DPM_REGS_SVH
`define DPM_REGS_SVH
`define DPM_CLK_PERIOD_NS      10
`define DPM_ACCESS_NS          25
`define DPM_FLOWTHROUGH_NS     30
`define DPM_RECOVERY_NS        15
`define DPM_BUSY_SETTLE_NS     20
`define DPM_SYNC_STAGES        2
`define DPM_ACCESS_CYC     ((`DPM_ACCESS_NS + `DPM_CLK_PERIOD_NS - 1) / `DPM_CLK_PERIOD_NS)
`define DPM_FLOW_CYC       ((`DPM_FLOWTHROUGH_NS + `DPM_CLK_PERIOD_NS - 1) / `DPM_CLK_PERIOD_NS)
`define DPM_RECOV_CYC      ((`DPM_RECOVERY_NS + `DPM_CLK_PERIOD_NS - 1) / `DPM_CLK_PERIOD_NS)
`define DPM_SETTLE_CYC     ((`DPM_BUSY_SETTLE_NS + `DPM_CLK_PERIOD_NS - 1) / `DPM_CLK_PERIOD_NS)
`define DPM_TOKEN_BIT      0
`define DPM_TOKEN_IDX_W    3
`endif

// file: shared/dpm_pkg.sv
// Types for the dual-port memory host controller
`default_nettype none
package dpm_pkg;
  typedef enum logic [1:0] {
    DPM_OP_READ,
    DPM_OP_WRITE,
    DPM_OP_TOKEN_READ,
    DPM_OP_TOKEN_WRITE
  } dpm_op_t;
  typedef enum {
    DPM_IDLE,
    DPM_SETTLE,
    DPM_STROBE,
    DPM_RECOVER
  } dpm_state_t;
endpackage
`default_nettype wire

// file: hdl/dpm_host.sv
// Host controller driving one port of an asynchronous dual-port memory
`default_nettype none
`include "dpm_regs.svh"
module dpm_host
  import dpm_pkg::*;
#(
  parameter int ADDR_W = 14,
  parameter int DATA_W = 16
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  clk_en,
  input  wire logic                  slave_mode,
  input  wire logic                  req_valid,
  output logic                       req_ready,
  input  wire dpm_pkg::dpm_op_t      req_op,
  input  wire logic [ADDR_W-1:0]     req_addr,
  input  wire logic [DATA_W-1:0]     req_wdata,
  input  wire logic [1:0]            req_lane_n,
  input  wire logic                  req_remote_wait,
  output logic                       rsp_valid,
  output logic [DATA_W-1:0]          rsp_rdata,
  output logic                       rsp_busy,
  output logic                       mail_pending,
  output logic                       port_enable_n,
  output logic                       write_strobe_n,
  output logic                       output_drive_n,
  output logic                       token_latch_select_n,
  output logic                       high_lane_select_n,
  output logic                       low_lane_select_n,
  output logic [ADDR_W-1:0]          addr,
  output logic [DATA_W-1:0]          data_o,
  output logic                       data_oe,
  input  wire logic [DATA_W-1:0]     data_i,
  input  wire logic                  busy_n,
  input  wire logic                  mailbox_flag_n
);
  import dpm_pkg::*;

  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] ACC_CYC   = CNT_W'(`DPM_ACCESS_CYC);
  localparam logic [CNT_W-1:0] FLOW_CYC  = CNT_W'(`DPM_FLOW_CYC);
  localparam logic [CNT_W-1:0] RECOV_CYC = CNT_W'(`DPM_RECOV_CYC);
  localparam logic [CNT_W-1:0] SETL_CYC  = CNT_W'(`DPM_SETTLE_CYC);
  localparam logic [CNT_W-1:0] SYNC_CYC  = CNT_W'(`DPM_SYNC_STAGES);

  typedef struct packed {
    dpm_state_t         st;
    logic [CNT_W-1:0]   cnt;
    dpm_op_t            op;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  wdata;
    logic [1:0]         lane_n;
    logic               remote;
    logic               rsp_valid;
    logic [DATA_W-1:0]  rdata;
    logic               busy_seen;
    logic [1:0]         busy_sync;
    logic [1:0]         mail_sync;
  } dpm_host_state_t;

  dpm_host_state_t s_reg, s_next;

  logic is_token;
  logic is_write;
  logic busy_now;
  logic [CNT_W-1:0] strobe_len;

  always_comb begin
    is_token   = (s_reg.op == DPM_OP_TOKEN_READ) || (s_reg.op == DPM_OP_TOKEN_WRITE);
    is_write   = (s_reg.op == DPM_OP_WRITE) || (s_reg.op == DPM_OP_TOKEN_WRITE);
    busy_now   = ~s_reg.busy_sync[1];
    // Remote data may land just as the strobe opens, so one spare cycle covers it
    strobe_len = (s_reg.remote && !is_write) ? FLOW_CYC + CNT_W'(1) : ACC_CYC;
  end

  always_comb begin
    s_next = s_reg;
    s_next.busy_sync = {s_reg.busy_sync[0], busy_n};
    s_next.mail_sync = {s_reg.mail_sync[0], mailbox_flag_n};
    s_next.rsp_valid = 1'b0;
    unique case (s_reg.st)
      DPM_IDLE: begin
        if (req_valid) begin
          s_next.op     = req_op;
          // Token data is masked here so the pin drive comes straight from a flop
          s_next.wdata  = (req_op == DPM_OP_TOKEN_WRITE)
                          ? DATA_W'(req_wdata[`DPM_TOKEN_BIT]) : req_wdata;
          s_next.lane_n = req_lane_n;
          s_next.remote = req_remote_wait;
          // Token accesses carry only the low three index bits
          s_next.addr = (req_op == DPM_OP_TOKEN_READ || req_op == DPM_OP_TOKEN_WRITE)
                        ? ADDR_W'(req_addr[`DPM_TOKEN_IDX_W-1:0]) : req_addr;
          s_next.busy_seen = 1'b0;
          // A slave write also waits out the busy synchroniser, else it acts on stale busy
          s_next.cnt = (slave_mode && req_op == DPM_OP_WRITE) ? SETL_CYC + SYNC_CYC
                                                                : SETL_CYC;
          s_next.st  = DPM_SETTLE;
        end
      end
      DPM_SETTLE: begin
        // Address is presented early so busy can settle before any strobe
        if (s_reg.cnt > CNT_W'(1)) begin
          s_next.cnt = s_reg.cnt - CNT_W'(1);
        end else if (!(slave_mode && busy_now && is_write && !is_token)) begin
          s_next.cnt = strobe_len;
          s_next.st  = DPM_STROBE;
        end
      end
      DPM_STROBE: begin
        if (busy_now) begin
          s_next.busy_seen = 1'b1;
        end
        if (s_reg.cnt > CNT_W'(1)) begin
          s_next.cnt = s_reg.cnt - CNT_W'(1);
        end else begin
          if (!is_write) begin
            // Token value is on every line; bit zero is the answer
            s_next.rdata = is_token ? {DATA_W{data_i[`DPM_TOKEN_BIT]}} : data_i;
          end
          s_next.cnt = RECOV_CYC;
          s_next.st  = DPM_RECOVER;
        end
      end
      DPM_RECOVER: begin
        // Selects stay released so a token readback sees settled state
        if (s_reg.cnt > CNT_W'(1)) begin
          s_next.cnt = s_reg.cnt - CNT_W'(1);
        end else begin
          s_next.rsp_valid = 1'b1;
          s_next.st = DPM_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '{st: DPM_IDLE, cnt: '0, op: DPM_OP_READ, addr: '0, wdata: '0,
                 lane_n: 2'b11, remote: 1'b0, rsp_valid: 1'b0, rdata: '0,
                 busy_seen: 1'b0, busy_sync: 2'b11, mail_sync: 2'b11};
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  always_comb begin
    req_ready    = (s_reg.st == DPM_IDLE);
    rsp_valid    = s_reg.rsp_valid;
    rsp_rdata    = s_reg.rdata;
    rsp_busy     = s_reg.busy_seen;
    mail_pending = ~s_reg.mail_sync[1];
    addr         = s_reg.addr;
    data_o       = s_reg.wdata;
    // Idle: both selects high so the device floats and powers down
    port_enable_n        = 1'b1;
    token_latch_select_n = 1'b1;
    write_strobe_n       = 1'b1;
    output_drive_n       = 1'b1;
    high_lane_select_n   = 1'b1;
    low_lane_select_n    = 1'b1;
    data_oe              = 1'b0;
    if (s_reg.st == DPM_SETTLE || s_reg.st == DPM_STROBE) begin
      if (is_token) begin
        token_latch_select_n = 1'b0;
      end else begin
        port_enable_n      = 1'b0;
        high_lane_select_n = s_reg.lane_n[1];
        low_lane_select_n  = s_reg.lane_n[0];
      end
    end
    if (s_reg.st == DPM_STROBE) begin
      write_strobe_n = ~is_write;
      output_drive_n = is_write;
      data_oe        = is_write;
    end
  end

  chk_token_no_enable: assert property (@(posedge core_clk) disable iff (rst)
    !token_latch_select_n |-> port_enable_n)
    else $error("port enable low during token access");

  chk_read_both_low: assert property (@(posedge core_clk) disable iff (rst)
    (s_reg.st == DPM_STROBE && !is_write && !is_token) |-> (!port_enable_n && !output_drive_n))
    else $error("read without enable and output drive");

  chk_idle_floats: assert property (@(posedge core_clk) disable iff (rst)
    req_ready |-> (port_enable_n && token_latch_select_n && !data_oe))
    else $error("idle port not deselected");

  chk_recovery_gap: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
    ($fell(token_latch_select_n) ##0 1) |-> $past(token_latch_select_n, 2))
    else $error("token select reasserted without recovery gap");

  chk_token_bit_only: assert property (@(posedge core_clk) disable iff (rst)
    (!token_latch_select_n && data_oe) |-> (data_o[DATA_W-1:1] == '0))
    else $error("token write drives upper bits");

  chk_slave_hold: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
    (slave_mode && $past(busy_now) && $past(s_reg.st) == DPM_SETTLE && $past(is_write)
     && !$past(is_token) && s_reg.st != DPM_SETTLE) |-> 1'b0)
    else $error("slave write started while busy");

  chk_strobe_excl: assert property (@(posedge core_clk) disable iff (rst)
    !(!write_strobe_n && !output_drive_n))
    else $error("write strobe and output drive both low");

endmodule
`default_nettype wire

// file: bench/dpm_mem_model.sv
// Behavioural model of the dual-port memory as seen from the left port
`default_nettype none
module dpm_mem_model (
  input  wire logic        core_clk,
  input  wire logic        port_enable_n,
  input  wire logic        write_strobe_n,
  input  wire logic        output_drive_n,
  input  wire logic        token_latch_select_n,
  input  wire logic        high_lane_select_n,
  input  wire logic        low_lane_select_n,
  input  wire logic [13:0] addr,
  input  wire logic [15:0] data_o,
  output logic [15:0]      data_i,
  output logic             busy_n,
  output logic             mailbox_flag_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:16383];
  logic [1:0]  own [0:7] = '{default: 2'h0};
  logic [2:0]  pend [0:7] = '{default: 3'h0};
  logic        flag_l = 1'b0, flag_r = 1'b0, rmt_on = 1'b0, rd_on = 1'b0, bad_sel = 1'b0;
  logic [13:0] rmt_addr = '0;
  logic [15:0] dq = '0;
  assign data_i = dq;
  assign mailbox_flag_n = !flag_l;
  assign busy_n = !(rmt_on && !port_enable_n && addr == rmt_addr);
  // Owner code 1 is the left port, 2 the right port, 0 free
  // Calls are serialised, so of two racing requests exactly the first one wins
  task automatic tok(input logic [1:0] me, input int i, input bit b);
    if (!b && own[i] == 2'h0) own[i] = me;
    else if (!b && own[i] != me) pend[i][me] = 1'b1;
    else if (b && own[i] == me) begin
      own[i] = pend[i][2'h3 - me] ? 2'h3 - me : 2'h0;
      pend[i] = '0;
    end else if (b) pend[i][me] = 1'b0;
  endtask
  task automatic rmt_write(input logic [13:0] a, input logic [15:0] d);
    mem[a] = d;
    if (a == 14'h3ffe) flag_l = 1'b1;
  endtask
  always @(negedge core_clk) begin
    bad_sel <= bad_sel | (!port_enable_n && !token_latch_select_n);
    if (!write_strobe_n && !port_enable_n && busy_n) begin
      if (!high_lane_select_n) mem[addr][15:8] <= data_o[15:8];
      if (!low_lane_select_n) mem[addr][7:0] <= data_o[7:0];
      if (addr == 14'h3fff) flag_r <= 1'b1;
    end
    if (!write_strobe_n && !token_latch_select_n) begin
      tok(2'h1, int'(addr[2:0]), data_o[0]);
    end
    if (!output_drive_n && !port_enable_n && busy_n && addr == 14'h3ffe) begin
      flag_l <= 1'b0;
    end
    // Released lines wander so a stale value is never mistaken for data
    if (output_drive_n) dq <= ~dq;
    else if (!rd_on) dq <= !token_latch_select_n ? {16{own[addr[2:0]] != 2'h1}} : mem[addr];
    rd_on <= !output_drive_n;
  end
endmodule
`default_nettype wire

// file: bench/dpm_host_tb.sv
// Self-checking bench for the dual-port memory host controller
`default_nettype none
`include "dpm_regs.svh"
module dpm_host_tb;
  import dpm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PLAIN_CYC  = `DPM_SETTLE_CYC + `DPM_ACCESS_CYC + `DPM_RECOV_CYC;
  localparam int REMOTE_CYC = `DPM_SETTLE_CYC + `DPM_FLOW_CYC + 1 + `DPM_RECOV_CYC;
  logic core_clk = 0, rst = 1, req_valid = 0, req_remote_wait = 0;
  logic clk_en = 1, slave_mode = 0;
  dpm_op_t req_op = DPM_OP_READ;
  logic [13:0] req_addr = '0, addr;
  logic [15:0] req_wdata = '0, rsp_rdata, data_o, data_i;
  logic [1:0] req_lane_n = '0;
  logic req_ready, rsp_valid, rsp_busy, mail_pending, port_enable_n, write_strobe_n;
  logic output_drive_n, token_latch_select_n, high_lane_select_n, low_lane_select_n;
  logic data_oe, busy_n, mailbox_flag_n;
  int num_errors = 0, n_compared = 0, last_wait = 0;
  always #5 core_clk = ~core_clk;
  dpm_host #(.ADDR_W(14), .DATA_W(16)) i_dut (.core_clk, .rst, .clk_en,
    .slave_mode, .req_valid, .req_ready, .req_op, .req_addr, .req_wdata, .req_lane_n,
    .req_remote_wait, .rsp_valid, .rsp_rdata, .rsp_busy, .mail_pending, .port_enable_n,
    .write_strobe_n, .output_drive_n, .token_latch_select_n, .high_lane_select_n,
    .low_lane_select_n, .addr, .data_o, .data_oe, .data_i, .busy_n, .mailbox_flag_n);
  dpm_mem_model i_mem (.core_clk, .port_enable_n, .write_strobe_n, .output_drive_n,
    .token_latch_select_n, .high_lane_select_n, .low_lane_select_n, .addr, .data_o,
    .data_i, .busy_n, .mailbox_flag_n);
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One request, then a bounded wait for its answer
  task automatic req(input dpm_op_t op, input logic [13:0] a, input logic [15:0] d,
                     input logic [1:0] ln, input logic rw = 1'b0);
    @(negedge core_clk);
    req_op          = op;
    req_addr        = a;
    req_wdata       = d;
    req_lane_n      = ln;
    req_remote_wait = rw;
    req_valid       = 1'b1;
    @(negedge core_clk);
    req_valid = 1'b0;
    for (last_wait = 0; last_wait < 20 && rsp_valid !== 1'b1; last_wait++) @(negedge core_clk);
    if (last_wait == 20) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  task automatic t_lanes();
    req(DPM_OP_WRITE, 14'h0005, 16'h1234, 2'b00);
    req(DPM_OP_WRITE, 14'h0005, 16'habcd, 2'b01);
    req(DPM_OP_READ, 14'h0005, 16'h0, 2'b00);
    chk(rsp_rdata, 16'hab34);
    req(DPM_OP_WRITE, 14'h0005, 16'h5678, 2'b10);
    req(DPM_OP_READ, 14'h0005, 16'h0, 2'b00);
    chk(rsp_rdata, 16'hab78);
    $display("lanes test done");
  endtask
  task automatic t_mail();
    {i_mem.rmt_addr, i_mem.rmt_on} = {14'h3fff, 1'b1};
    req(DPM_OP_WRITE, 14'h3fff, 16'h0099, 2'b00);
    chk(16'(rsp_busy), 16'h1);
    chk(16'(i_mem.flag_r), 16'h0);
    i_mem.rmt_on = 0;
    req(DPM_OP_WRITE, 14'h3fff, 16'h0042, 2'b00);
    chk(16'(i_mem.flag_r), 16'h1);
    req(DPM_OP_READ, 14'h3fff, 16'h0, 2'b00);
    chk(rsp_rdata, 16'h0042);
    chk(16'(i_mem.flag_r), 16'h1);
    i_mem.rmt_write(14'h3ffe, 16'hc0de);
    {i_mem.rmt_addr, i_mem.rmt_on} = {14'h3ffe, 1'b1};
    req(DPM_OP_READ, 14'h3ffe, 16'h0, 2'b00);
    chk(16'(mail_pending), 16'h1);
    i_mem.rmt_on = 0;
    req(DPM_OP_READ, 14'h3ffe, 16'h0, 2'b00);
    chk(rsp_rdata, 16'hc0de);
    repeat (4) @(negedge core_clk);
    chk(16'(mail_pending), 16'h0);
    $display("mailbox test done");
  endtask
  task automatic t_token();
    req(DPM_OP_TOKEN_WRITE, 14'h0003, 16'hfffe, 2'b11);
    req(DPM_OP_TOKEN_READ, 14'h0003, 16'h0, 2'b11);
    chk(rsp_rdata, 16'h0000);
    i_mem.tok(2'h2, 3, 1'b0);
    req(DPM_OP_TOKEN_READ, 14'h0003, 16'h0, 2'b11);
    chk(rsp_rdata, 16'h0000);
    req(DPM_OP_TOKEN_WRITE, 14'h0003, 16'h0001, 2'b11);
    req(DPM_OP_TOKEN_READ, 14'h0003, 16'h0, 2'b11);
    chk(rsp_rdata, 16'hffff);
    chk(16'(i_mem.bad_sel), 16'h0);
    $display("token test done");
  endtask
  // Slave write held off while busy stands, then released once it clears
  task automatic t_slave();
    slave_mode = 1'b1;
    {i_mem.rmt_addr, i_mem.rmt_on} = {14'h0030, 1'b1};
    fork
      req(DPM_OP_WRITE, 14'h0030, 16'h1357, 2'b00);
      begin
        repeat (8) @(negedge core_clk);
        chk(16'({write_strobe_n, port_enable_n}), 16'h2);
        i_mem.rmt_on = 1'b0;
      end
    join
    chk(16'(rsp_busy), 16'h0);
    slave_mode = 1'b0;
    req(DPM_OP_READ, 14'h0030, 16'h0, 2'b00);
    chk(rsp_rdata, 16'h1357);
    $display("slave test done");
  endtask
  // Remote-read stretch and clock-enable freeze, judged by answer latency
  task automatic t_timing();
    i_mem.rmt_write(14'h0020, 16'h5a5a);
    req(DPM_OP_READ, 14'h0020, 16'h0, 2'b00, 1'b1);
    chk(rsp_rdata, 16'h5a5a);
    chk(16'(last_wait), 16'(REMOTE_CYC));
    req(DPM_OP_READ, 14'h0020, 16'h0, 2'b00);
    chk(16'(last_wait), 16'(PLAIN_CYC));
    fork
      req(DPM_OP_READ, 14'h0005, 16'h0, 2'b00);
      begin
        repeat (2) @(negedge core_clk);
        clk_en = 1'b0;
        repeat (5) @(negedge core_clk);
        chk(16'({req_ready, port_enable_n, rsp_valid}), 16'h0);
        clk_en = 1'b1;
      end
    join
    chk(rsp_rdata, 16'hab78);
    chk(16'(last_wait), 16'(PLAIN_CYC + 5));
    $display("timing test done");
  endtask
  initial begin
    repeat (4) @(negedge core_clk);
    rst = 0;
    t_lanes();
    t_mail();
    t_token();
    t_slave();
    t_timing();
    report_and_stop();
  end
endmodule
`default_nettype wire
